// >>> rtl/sleep_sub_defs.vh
// Constants shared by the power-down and literal-subtract execution logic
`ifndef SLEEP_SUB_DEFS_VH
`define SLEEP_SUB_DEFS_VH

// Opcodes
`define OPC_POWER_DOWN 14'h0063
`define OPC_SUBLIT_HI 5'h1e
`define OPC_SUBLIT_MSB 13
`define OPC_SUBLIT_LSB 9

// Register byte offsets on the bus
`define REG_ACC 8'h00
`define REG_STATUS 8'h04
`define REG_CTRL 8'h08
`define REG_WATCHDOG 8'h0c

// Status register field positions
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define ST_PDOWN 3
`define ST_TIMEOUT 4
`define ST_HALTED 5

// Control register field positions
`define CT_WATCHDOG_EN 0
`define CT_WAKE 1

// Reset values
`define RST_ACC 8'h00
`define RST_TIMEOUT 1'b1
`define RST_PDOWN 1'b1
`define RST_WATCHDOG_EN 1'b0
`define WATCHDOG_ZERO 8'h00
`define PRESCALE_ZERO 8'h00
`define PRESCALE_LAST 8'hff

`endif

// >>> rtl/lit_sub_alu.v
// Eight-bit literal-minus-accumulator subtractor with carry, nibble and zero flags
module lit_sub_alu (
	// Operands
	input wire [7:0] i_literal,
	input wire [7:0] i_acc,
	// Result and flags
	output wire [7:0] o_diff,
	output wire o_no_borrow,
	output wire o_nibble_no_borrow,
	output wire o_zero
);

	wire [8:0] full_sum;
	wire [4:0] low_sum;

	// Two's complement: literal plus inverted accumulator plus one (see [RULE7])
	assign full_sum = {1'b0, i_literal} + {1'b0, ~i_acc} + 9'h001;
	assign low_sum = {1'b0, i_literal[3:0]} + {1'b0, ~i_acc[3:0]} + 5'h01;

	assign o_diff = full_sum[7:0];
	// Carry out of the sum is the inverted borrow (see [RULE9])
	assign o_no_borrow = full_sum[8];
	// Carry out of bit 3 is the inverted nibble borrow (see [RULE10])
	assign o_nibble_no_borrow = low_sum[4];
	assign o_zero = (full_sum[7:0] == 8'h00);

endmodule

// >>> rtl/sleep_and_sub_literal_exec.v
// Execution of the power-down and subtract-from-literal instructions with a Wishbone slave
// What this block does
// [RULE1] Power-down opcode halts the core after the instruction; no further execution. Here i_wake or the control wake bit resumes execution.
// [RULE2] Entering halt stops the main oscillator so no core clocks occur.
// [RULE3] Power-down clears power_down_flag to 0.
// [RULE4] Power-down sets timeout_flag to 1.
// [RULE5] Power-down zeroes watchdog_counter and its prescaler.
// [RULE6] Subtract-from-literal decodes as 11 110x; low eight bits are the immediate.
// [RULE7] Datapath computes immediate minus accumulator in 8-bit two's complement.
// [RULE8] The difference always goes to the accumulator; no file register changes.
// [RULE9] Carry is 1 for zero or positive result, 0 when a borrow occurs.
// [RULE10] Nibble flag is inverted borrow from bit 3; zero flag marks a zero result.
// [RULE11] Both instructions take one program word and one instruction cycle.
`include "sleep_sub_defs.vh"

module sleep_and_sub_literal_exec (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_b,
	// Instruction stream, one word per instruction cycle
	input wire [13:0] i_instr,
	input wire i_instr_valid,
	// External wake request
	input wire i_wake,
	// Wishbone slave
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [7:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	output wire [31:0] o_wb_dat,
	output wire o_wb_ack,
	// Core state
	output wire [7:0] o_acc,
	output wire o_carry,
	output wire o_nibble_borrow_flag,
	output wire o_zero,
	output wire o_timeout_flag,
	output wire o_power_down_flag,
	output wire o_halted,
	output wire o_osc_run,
	output wire o_retired,
	output wire [7:0] o_watchdog_counter,
	output wire [7:0] o_watchdog_prescale
);

	// Core run states
	localparam ST_RUN = 2'b01;
	localparam ST_HALT = 2'b10;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [7:0] acc_r;
	reg carry_r;
	reg nibble_r;
	reg zero_r;
	reg timeout_flag_r;
	reg power_down_flag_r;
	reg watchdog_en_r;
	reg [7:0] watchdog_counter_r;
	reg [7:0] prescale_r;
	reg retired_r;
	reg ack_r;
	reg [31:0] rdata_r;
	reg [31:0] rdata_nxt;

	wire running;
	wire exec;
	wire is_power_down;
	wire is_sub_literal;
	wire [7:0] immediate_byte;
	wire [7:0] diff;
	wire no_borrow;
	wire nibble_no_borrow;
	wire diff_zero;
	wire bus_req;
	wire bus_write;
	wire acc_write;
	wire ctrl_write;
	wire wake_req;

	assign running = (state_r == ST_RUN);
	// Only a running core executes; words presented while halted are dropped
	assign exec = running & i_instr_valid; // see [RULE1]
	assign is_power_down = exec & (i_instr == `OPC_POWER_DOWN); // see [RULE1]
	// Bit 8 of the opcode is ignored (see [RULE6])
	assign is_sub_literal = exec &
		(i_instr[`OPC_SUBLIT_MSB:`OPC_SUBLIT_LSB] == `OPC_SUBLIT_HI); // see [RULE6]
	assign immediate_byte = i_instr[7:0]; // see [RULE6]

	lit_sub_alu u_alu (
		.i_literal(immediate_byte),
		.i_acc(acc_r),
		.o_diff(diff),
		.o_no_borrow(no_borrow),
		.o_nibble_no_borrow(nibble_no_borrow),
		.o_zero(diff_zero)
	);

	// Bus decode; writes land on the acknowledging edge
	assign bus_req = i_wb_cyc & i_wb_stb;
	assign bus_write = bus_req & i_wb_we & ack_r & i_wb_sel[0];
	assign acc_write = bus_write & (i_wb_adr == `REG_ACC);
	assign ctrl_write = bus_write & (i_wb_adr == `REG_CTRL);
	assign wake_req = i_wake | (ctrl_write & i_wb_dat[`CT_WAKE]);

	// Run/halt sequencing
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				// Halt takes effect at the edge that retires the power-down word
				if (is_power_down) begin
					state_nxt = ST_HALT; // see [RULE1] [RULE11]
				end
			end
			ST_HALT: begin
				if (wake_req) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Accumulator: the instruction wins over a bus write in the same cycle
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			acc_r <= `RST_ACC;
		end else if (is_sub_literal) begin
			acc_r <= diff; // see [RULE8] [RULE11]
		end else if (acc_write) begin
			acc_r <= i_wb_dat[7:0];
		end
	end

	// Arithmetic flags
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			carry_r <= 1'b0;
			nibble_r <= 1'b0;
			zero_r <= 1'b0;
		end else if (is_sub_literal) begin
			carry_r <= no_borrow; // see [RULE9]
			nibble_r <= nibble_no_borrow; // see [RULE10]
			zero_r <= diff_zero; // see [RULE10]
		end
	end

	// Power status flags; both read 1 after reset
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			timeout_flag_r <= `RST_TIMEOUT;
			power_down_flag_r <= `RST_PDOWN;
		end else if (is_power_down) begin
			timeout_flag_r <= 1'b1; // see [RULE4]
			power_down_flag_r <= 1'b0; // see [RULE3]
		end
	end

	// Watchdog: prescaler wraps into the counter; it keeps counting while halted
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			watchdog_counter_r <= `WATCHDOG_ZERO;
			prescale_r <= `PRESCALE_ZERO;
		end else if (is_power_down) begin
			watchdog_counter_r <= `WATCHDOG_ZERO; // see [RULE5]
			prescale_r <= `PRESCALE_ZERO; // see [RULE5]
		end else if (watchdog_en_r) begin
			prescale_r <= prescale_r + 8'h01;
			if (prescale_r == `PRESCALE_LAST) begin
				watchdog_counter_r <= watchdog_counter_r + 8'h01;
			end
		end
	end

	// Control register and retire pulse
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			watchdog_en_r <= `RST_WATCHDOG_EN;
			retired_r <= 1'b0;
		end else begin
			if (ctrl_write) begin
				watchdog_en_r <= i_wb_dat[`CT_WATCHDOG_EN];
			end
			// Running power-down and subtract-literal words raise the retire pulse the cycle after they are presented; halted or other words raise none
			retired_r <= is_power_down | is_sub_literal; // see [RULE11]
		end
	end

	// Read mux; unmapped offsets read as zero
	always @* begin
		rdata_nxt = 32'h00000000;
		case (i_wb_adr)
			`REG_ACC: begin
				rdata_nxt[7:0] = acc_r;
			end
			`REG_STATUS: begin
				rdata_nxt[`ST_CARRY] = carry_r;
				rdata_nxt[`ST_NIBBLE] = nibble_r;
				rdata_nxt[`ST_ZERO] = zero_r;
				rdata_nxt[`ST_PDOWN] = power_down_flag_r;
				rdata_nxt[`ST_TIMEOUT] = timeout_flag_r;
				rdata_nxt[`ST_HALTED] = ~running;
			end
			`REG_CTRL: begin
				rdata_nxt[`CT_WATCHDOG_EN] = watchdog_en_r;
			end
			`REG_WATCHDOG: begin
				rdata_nxt[15:0] = {prescale_r, watchdog_counter_r};
			end
			default: begin
				rdata_nxt = 32'h00000000;
			end
		endcase
	end

	// Ack one cycle after the request, dropped the next cycle
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r <= bus_req & ~ack_r;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rdata_r;
	assign o_acc = acc_r;
	assign o_carry = carry_r;
	assign o_nibble_borrow_flag = nibble_r;
	assign o_zero = zero_r;
	assign o_timeout_flag = timeout_flag_r;
	assign o_power_down_flag = power_down_flag_r;
	assign o_halted = ~running;
	// Clock controller gates the core clock off with this (see [RULE2])
	assign o_osc_run = running;
	assign o_retired = retired_r;
	assign o_watchdog_counter = watchdog_counter_r;
	assign o_watchdog_prescale = prescale_r;

endmodule

// >>> verification/sse_props.sv
// Assertions on the power-down and literal-subtract block
module sse_props (
	// Clock, reset and instruction in
	input logic i_clk,
	input logic i_rst_b,
	input logic [13:0] i_instr,
	input logic i_instr_valid,
	// Core state
	input logic [7:0] o_acc,
	input logic o_carry,
	input logic o_nibble_borrow_flag,
	input logic o_zero,
	input logic o_timeout_flag,
	input logic o_power_down_flag,
	input logic o_halted,
	input logic o_osc_run,
	input logic o_retired,
	input logic [7:0] o_watchdog_counter,
	input logic [7:0] o_watchdog_prescale
);
timeunit 1ns;
timeprecision 1ps;
wire sub = i_instr_valid && !o_halted && i_instr[13:9] == 5'h1e;
wire sleep_dec = i_instr_valid && !o_halted && i_instr == 14'h0063;
wire dec = sub || sleep_dec;
wire [7:0] k = i_instr[7:0];
wire [3:0] kl = i_instr[3:0];
wire [3:0] al = o_acc[3:0];
default clocking @(posedge i_clk);
endclocking
default disable iff (!i_rst_b);
a_sub_acc: assert property (sub |=> o_acc == $past(k) - $past(o_acc))
	else $error("bad difference");
a_sub_carry: assert property (sub |=> o_carry == ($past(k) >= $past(o_acc)))
	else $error("bad carry");
a_sub_nibble:
	assert property (sub |=> o_nibble_borrow_flag == ($past(kl) >= $past(al)))
	else $error("bad nibble flag");
a_sub_zero: assert property (sub |=> o_zero == (o_acc == 8'h00))
	else $error("bad zero flag");
a_sleep_status:
	assert property (sleep_dec |=> o_halted && o_timeout_flag && !o_power_down_flag)
	else $error("bad status after power-down");
a_sleep_watchdog_clear:
	assert property (sleep_dec |=> o_watchdog_counter == 8'h00 && o_watchdog_prescale == 8'h00)
	else $error("watchdog not cleared");
a_sleep_osc_stop: assert property (sleep_dec |=> !o_osc_run)
	else $error("oscillator still running after power-down");
a_halt_idle: assert property (o_halted |=> !o_retired)
	else $error("executed while halted");
a_retire_dec: assert property (o_retired == $past(dec))
	else $error("bad retire pulse");
endmodule
bind sleep_and_sub_literal_exec sse_props u_sse_props (.*);

// >>> verification/tb_sleep_and_sub_literal_exec.sv
// Self-checking bench for the power-down and literal-subtract block
module tb_sleep_and_sub_literal_exec;
timeunit 1ns;
timeprecision 1ps;
logic i_clk = 1'h0, i_rst_b = 1'h0, i_instr_valid = 1'h0, i_wake = 1'h0;
logic i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
logic [13:0] i_instr = 14'h0;
logic [7:0] i_wb_adr = 8'h0;
logic [3:0] i_wb_sel = 4'h1;
logic [31:0] i_wb_dat = 32'h0;
wire [31:0] o_wb_dat;
wire [7:0] o_acc, o_watchdog_counter, o_watchdog_prescale;
wire o_wb_ack, o_carry, o_nibble_borrow_flag, o_zero, o_timeout_flag, o_power_down_flag;
wire o_halted, o_osc_run, o_retired;
int n_mismatch = 0, cmp_count = 0, cyc = 0;
logic [95:0] cor = 96'h0201_0202_0203_1001_00ff_ff00;
sleep_and_sub_literal_exec u_sleep_and_sub_literal_exec (.*);
initial forever #12.5 i_clk = ~i_clk;
function automatic logic [31:0] lfsr(input logic [31:0] s);
	return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
// Result, no-borrow, nibble no-borrow, zero
function automatic logic [10:0] expect_sub(input logic [7:0] k, w);
	return {k - w, k >= w, k[3:0] >= w[3:0], k == w};
endfunction
task automatic chk(input string nm, input logic [31:0] s, e);
	cmp_count++;
	if (s !== e) begin
		n_mismatch++;
		$display("MISMATCH %s expected %h seen %h", nm, e, s);
	end
endtask
task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
	@(posedge i_clk);
	i_wb_cyc <= 1'h1;
	i_wb_stb <= 1'h1;
	i_wb_we <= w;
	i_wb_adr <= a;
	i_wb_dat <= d;
	do @(posedge i_clk); while (o_wb_ack !== 1'h1);
	q = o_wb_dat;
	i_wb_cyc <= 1'h0;
	i_wb_stb <= 1'h0;
endtask
// Ends mid-cycle so the executing edge's updates have landed
task automatic ex(input logic [13:0] w);
	@(posedge i_clk);
	i_instr <= w;
	i_instr_valid <= 1'h1;
	@(posedge i_clk);
	i_instr_valid <= 1'h0;
	@(negedge i_clk);
endtask
task automatic summarize;
	$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
	if (n_mismatch == 0 && cmp_count > 0) begin
		$display("No errors found");
	end else begin
		$display("Errors were found");
	end
	$finish;
endtask
always @(posedge i_clk) begin
	cyc <= cyc + 1;
	if (cyc == 2000) begin
		n_mismatch++;
		summarize();
	end
end
initial begin
	logic [31:0] q, r;
	logic [7:0] k, w;
	logic [10:0] e;
	r = 32'hfb17;
	w = 8'h0;
	repeat (3) @(posedge i_clk);
	i_rst_b <= 1'h1;
	wb(1'h0, 8'hf0, 32'h0, q);
	chk("unmapped", q, 32'h0);
	wb(1'h0, 8'h04, 32'h0, q);
	chk("reset status", q, 32'h18);
	wb(1'h1, 8'h08, 32'h1, q);
	for (int i = 0; i < 40; i++) begin
		r = lfsr(r);
		k = i < 6 ? cor[i*16+8 +: 8] : r[7:0];
		if (i < 6 || r[9]) begin
			w = i < 6 ? cor[i*16 +: 8] : r[23:16];
			wb(1'h1, 8'h00, {24'h0, w}, q);
		end
		ex({5'h1e, r[8], k});
		e = expect_sub(k, w);
		w = e[10:3];
		chk("acc", o_acc, w);
		chk("flags", {o_carry, o_nibble_borrow_flag, o_zero}, e[2:0]);
		chk("retired", o_retired, 32'h1);
	end
	wb(1'h0, 8'h00, 32'h0, q);
	chk("acc read", q, w);
	// A write with byte lane 0 off must leave the accumulator alone
	i_wb_sel <= 4'he;
	wb(1'h1, 8'h00, {24'h0, ~w}, q);
	i_wb_sel <= 4'h1;
	wb(1'h0, 8'h00, 32'h0, q);
	chk("sel drop", q, w);
	ex(14'h3a55);
	chk("other op", {o_retired, o_acc}, w);
	ex(14'h0063);
	chk("halt", {o_halted, o_osc_run}, 32'h2);
	chk("status", {o_timeout_flag, o_power_down_flag}, 32'h2);
	chk("watchdog", {o_watchdog_counter, o_watchdog_prescale}, 32'h0);
	@(negedge i_clk);
	chk("watchdog run", {o_watchdog_counter, o_watchdog_prescale}, 32'h1);
	ex(14'h3c00);
	chk("halted op", {o_retired, o_acc}, w);
	wb(1'h0, 8'h04, 32'h0, q);
	chk("halt status", q, {26'h0, 3'b110, e[0], e[1], e[2]});
	@(posedge i_clk);
	i_wake <= 1'h1;
	@(posedge i_clk);
	i_wake <= 1'h0;
	ex(14'h3dff);
	chk("woken", o_acc, 8'hff - w);
	// Leave halt by the control register's wake bit this time
	ex(14'h0063);
	wb(1'h1, 8'h08, 32'h3, q);
	@(negedge i_clk);
	chk("ctrl wake", o_halted, 32'h0);
	// Reset in mid-run while halted must bring the core back to its reset state
	ex(14'h0063);
	@(posedge i_clk);
	i_rst_b <= 1'h0;
	@(posedge i_clk);
	i_rst_b <= 1'h1;
	@(negedge i_clk);
	chk("reset core", {o_halted, o_osc_run, o_acc}, 32'h100);
	chk("reset flags", {o_carry, o_nibble_borrow_flag, o_zero}, 32'h0);
	chk("reset power", {o_timeout_flag, o_power_down_flag}, 32'h3);
	chk("reset watchdog", {o_watchdog_counter, o_watchdog_prescale}, 32'h0);
	wb(1'h0, 8'h08, 32'h0, q);
	chk("reset ctrl", q, 32'h0);
	summarize();
end
endmodule
